// [rtl/rpm_ctrl.sv]
`timescale 1ns/10ps

module rpm_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        oscillator_input_i,
    input  wire logic        reset_pin_i,
    input  wire logic        external_program_select_i,
    input  wire logic        power_write_i,
    input  wire logic [1:0]  power_data_i,
    input  wire logic        irq_pending_i,
    input  wire logic        cpu_ale_i,
    input  wire logic        cpu_fetch_strobe_i,
    input  wire logic [31:0] cpu_port_i,
    input  wire logic        cpu_port0_oe_i,
    output logic             ale_o,
    output logic             program_fetch_strobe_o,
    output logic [31:0]      port_o,
    output logic             port0_oe_o,
    output logic             oscillator_run_o,
    output logic             machine_phase_o,
    output logic             cpu_reset_o,
    output logic             cpu_halt_o,
    output logic             periph_halt_o,
    output logic             ext_program_o,
    output rpm_pkg::rpm_mode_t mode_o
);
    import rpm_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic       osc_s;
    logic       rst_pin_s;
    logic       ext_pin_s;

    rpm_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({external_program_select_i, reset_pin_i, oscillator_input_i}),
        .q_o     (pins_s)
    );

    assign osc_s     = pins_s[0];
    assign rst_pin_s = pins_s[1];
    assign ext_pin_s = pins_s[2];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    rpm_state_t r;
    rpm_state_t next_r;
    logic       osc_rise;
    logic       reset_hit;
    logic       use_ext;

    assign osc_rise  = osc_s & ~r.osc_prev;
    assign use_ext   = ~r.ext_sel;                  // Select low means external memory
    assign reset_hit = (next_r.cnt == RESET_COUNT_DONE);

    // Next state: clock divider, reset qualifier, mode sequencing, pins
    always_comb begin
        next_r          = r;
        next_r.osc_prev = osc_s;
        // Toggle once per oscillator period
        if (osc_rise) begin
            next_r.div = ~r.div;
        end
        // Count oscillator periods while the pin stays high
        if (!rst_pin_s) begin
            next_r.cnt = RESET_COUNT_ZERO;
        end else if (osc_rise && (r.cnt != RESET_COUNT_DONE)) begin
            next_r.cnt = r.cnt + 5'h01;
        end
        // Mode sequencing
        case (r.mode)
            MODE_RUN: begin
                if (power_write_i && power_data_i[POWER_DOWN_BIT]) begin
                    next_r.mode = MODE_PDOWN;
                end else if (power_write_i && power_data_i[POWER_IDLE_BIT]) begin
                    next_r.mode = MODE_IDLE;
                end
            end
            MODE_IDLE: begin
                if (irq_pending_i) begin
                    next_r.mode = MODE_RUN;
                end
            end
            MODE_PDOWN: begin
                next_r.mode = MODE_PDOWN;
            end
            MODE_RESET: begin
                if (!rst_pin_s) begin
                    next_r.mode = MODE_RUN;
                end
            end
            default: begin
                next_r.mode = MODE_RESET;
            end
        endcase
        // A qualified reset overrides every mode
        if (next_r.cnt == RESET_COUNT_DONE) begin
            next_r.mode = MODE_RESET;
        end
        // Catch the select while in reset; the last catch is the cycle of release
        if (r.mode == MODE_RESET) begin
            next_r.ext_sel = ext_pin_s;
        end
        // Clock gating outputs
        next_r.cpu_reset   = (next_r.mode == MODE_RESET);
        next_r.cpu_halt    = (next_r.mode == MODE_IDLE) || (next_r.mode == MODE_PDOWN);
        next_r.periph_halt = (next_r.mode == MODE_PDOWN);
        next_r.osc_run     = !((next_r.mode == MODE_PDOWN) && !rst_pin_s);
        // Pin states per mode
        case (next_r.mode)
            MODE_RUN: begin
                next_r.ale      = cpu_ale_i;
                next_r.fetch_strobe = cpu_fetch_strobe_i;
                next_r.port     = cpu_port_i;
                next_r.port0_oe = cpu_port0_oe_i;
            end
            MODE_IDLE: begin
                next_r.ale  = 1'b1;
                next_r.fetch_strobe = 1'b1;
                if (~next_r.ext_sel) begin
                    next_r.port0_oe = 1'b0;
                end
            end
            MODE_PDOWN: begin
                next_r.ale  = 1'b0;
                next_r.fetch_strobe = 1'b0;
                if (~next_r.ext_sel) begin
                    next_r.port0_oe = 1'b0;
                end
            end
            default: begin
                next_r.ale      = 1'b1;
                next_r.fetch_strobe = 1'b1;
                next_r.port     = PORT_RESET_VALUE;
                next_r.port0_oe = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= RPM_STATE_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign ale_o                  = r.ale;
    assign program_fetch_strobe_o = r.fetch_strobe;
    assign port_o                 = r.port;
    assign port0_oe_o             = r.port0_oe;
    assign oscillator_run_o       = r.osc_run;
    assign machine_phase_o        = r.div;
    assign cpu_reset_o            = r.cpu_reset;
    assign cpu_halt_o             = r.cpu_halt;
    assign periph_halt_o          = r.periph_halt;
    assign ext_program_o          = r.ext_sel;
    assign mode_o                 = r.mode;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_reset_qualify: assert property (
        (r.cnt == RESET_COUNT_DONE - 5'h01) && osc_rise && rst_pin_s
        |=> (r.mode == MODE_RESET) && r.cpu_reset)
        else $error("reset not taken after 24 oscillator periods");

    a_short_pulse: assert property (
        (r.mode == MODE_RUN) && (r.cnt < RESET_COUNT_DONE - 5'h01)
        |=> (r.mode != MODE_RESET))
        else $error("reset taken before 24 oscillator periods");

    a_select_frozen: assert property (
        (r.mode != MODE_RESET) ##1 (r.mode != MODE_RESET) |-> $stable(r.ext_sel))
        else $error("program memory select changed outside reset");

    a_divider_step: assert property (
        osc_rise |=> (r.div != $past(r.div)))
        else $error("divider did not toggle on oscillator edge");

    a_idle_enter: assert property (
        (r.mode == MODE_RUN) && power_write_i && power_data_i[POWER_IDLE_BIT]
        && !power_data_i[POWER_DOWN_BIT] && !rst_pin_s
        |=> r.cpu_halt && !r.periph_halt && r.ale && r.fetch_strobe)
        else $error("idle entry wrong");

    a_ports_held: assert property (
        (r.mode == MODE_IDLE) ##1 (r.mode == MODE_IDLE) |-> $stable(r.port))
        else $error("ports changed during idle");

    a_idle_wake: assert property (
        (r.mode == MODE_IDLE) && irq_pending_i && !rst_pin_s
        |=> (r.mode == MODE_RUN) && !r.cpu_halt)
        else $error("enabled interrupt did not end idle");

    a_idle_reset: assert property (
        (r.mode == MODE_IDLE) && reset_hit |=> r.cpu_reset && !r.cpu_halt)
        else $error("qualified reset did not end idle");

    a_osc_stopped: assert property (
        (r.mode == MODE_PDOWN) && !rst_pin_s |=> !r.osc_run && r.periph_halt)
        else $error("oscillator running in power-down");

    a_pdown_stays: assert property (
        (r.mode == MODE_PDOWN) && !rst_pin_s |=> (r.mode == MODE_PDOWN)[*1])
        else $error("power-down left without reset");

    a_idle_pins: assert property (
        (r.mode == MODE_IDLE) |-> r.ale && r.fetch_strobe && !(use_ext && r.port0_oe))
        else $error("pin states wrong in idle");

    a_pdown_pins: assert property (
        (r.mode == MODE_PDOWN) |-> !r.ale && !r.fetch_strobe && !(use_ext && r.port0_oe))
        else $error("pin states wrong in power-down");

    a_reset_release: assert property (
        (r.mode == MODE_RESET) && !rst_pin_s |=> (r.mode == MODE_RUN) && !r.cpu_halt)
        else $error("reset release did not return to run");

    c_idle_wake: cover property (
        (r.mode == MODE_IDLE) ##1 (r.mode == MODE_RUN));
    c_pdown_reset: cover property (
        (r.mode == MODE_PDOWN) ##[1:200] (r.mode == MODE_RESET));
    c_idle_reset: cover property (
        (r.mode == MODE_IDLE) ##1 (r.mode == MODE_RESET));
    c_run_entry: cover property (
        (r.mode == MODE_RESET) ##1 (r.mode == MODE_RUN));

endmodule // rpm_ctrl

// [rtl/rpm_pkg.sv]
package rpm_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned OSC_PER_MACHINE      = 12;  // Oscillator periods per machine cycle
    localparam int unsigned RESET_MACHINE_CYCLES = 2;   // Least reset pin hold, machine cycles
    localparam int unsigned RESET_OSC_PERIODS    = OSC_PER_MACHINE * RESET_MACHINE_CYCLES;
    localparam logic [4:0]  RESET_COUNT_DONE     = 5'(RESET_OSC_PERIODS);
    localparam logic [4:0]  RESET_COUNT_ZERO     = 5'h00;

    // ----------------------------------------------------------------
    // Power control register fields
    // ----------------------------------------------------------------
    localparam int unsigned POWER_IDLE_BIT = 0;         // Idle request bit position
    localparam int unsigned POWER_DOWN_BIT = 1;         // Power-down request bit position

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [31:0] PORT_RESET_VALUE = 32'hffffffff;
    localparam logic [7:0]  PORT_LANE_WIDTH  = 8'h08;

    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_IDLE  = 2'b01,
        MODE_PDOWN = 2'b10,
        MODE_RESET = 2'b11
    } rpm_mode_t;

    // ----------------------------------------------------------------
    // Controller state
    // ----------------------------------------------------------------
    typedef struct packed {
        rpm_mode_t   mode;        // Current operating mode
        logic        osc_prev;    // Synchronised oscillator, one cycle late
        logic        div;         // Divide-by-two stage
        logic [4:0]  cnt;         // Oscillator periods seen with reset pin high
        logic        ext_sel;     // Program memory select caught in reset
        logic        ale;         // Address latch strobe
        logic        fetch_strobe; // Program fetch strobe
        logic [31:0] port;        // Port 3..0 output data
        logic        port0_oe;    // Port 0 drive enable
        logic        osc_run;     // Oscillator amplifier enable
        logic        cpu_reset;   // Core reset
        logic        cpu_halt;    // Core clock stopped
        logic        periph_halt; // Peripheral clocks stopped
    } rpm_state_t;

    localparam rpm_state_t RPM_STATE_RESET = '{
        mode:        MODE_RESET,
        osc_prev:    1'b1,        // Matches the synchroniser's reset level
        div:         1'b0,
        cnt:         RESET_COUNT_ZERO,
        ext_sel:     1'b1,
        ale:         1'b1,
        fetch_strobe: 1'b1,
        port:        PORT_RESET_VALUE,
        port0_oe:    1'b0,
        osc_run:     1'b1,
        cpu_reset:   1'b1,
        cpu_halt:    1'b0,
        periph_halt: 1'b0
    };

endpackage

// [rtl/rpm_sync.sv]
`timescale 1ns/10ps

module rpm_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } rpm_sync_state_t;

    rpm_sync_state_t r;
    rpm_sync_state_t next_r;

    // First stage feeds only the second stage
    always_comb begin
        next_r.meta = d_i;
        next_r.sync = r.meta;
    end

    // Two flip-flop synchroniser; ones in reset so a reset pin reads as held
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.sync;

endmodule // rpm_sync

// [tb/rpm_board.sv]
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Board reset circuit and program memory select
// ----------------------------------------------------------------
module rpm_board (
    input  wire logic clk_i,
    input  wire logic oscillator_run_i,
    output logic      oscillator_o,
    output logic      reset_pin_o,
    output logic      select_o
);
    logic [1:0] div_cnt;

    // Quiet board at power-on
    initial begin
        oscillator_o = 1'b0;
        reset_pin_o  = 1'b0;
        select_o     = 1'b1;
        div_cnt      = 2'h0;
    end

    // Crystal toggles every 4 clocks, stands still while disabled
    always @(posedge clk_i) begin
        if (oscillator_run_i) begin
            div_cnt <= div_cnt + 2'h1;
            if (div_cnt == 2'h3) begin
                oscillator_o <= ~oscillator_o;
            end
        end
    end

    // Holds the reset pin high for a count of oscillator periods
    task automatic press_reset(input int periods);
        @(posedge clk_i);
        #1 reset_pin_o = 1'b1;
        repeat (periods) @(posedge oscillator_o);
        @(posedge clk_i);
        #1 reset_pin_o = 1'b0;
    endtask

    // Sets the program memory select level
    task automatic set_select(input logic level);
        @(posedge clk_i);
        #1 select_o = level;
    endtask
endmodule // rpm_board

// [tb/tb_top.sv]
`timescale 1ns/10ps

module tb_top;
    import rpm_pkg::*;

    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        osc, pin, sel;
    logic        power_write_i = 1'b0;
    logic [1:0]  power_data_i = 2'h0;
    logic        irq_pending_i = 1'b0;
    logic        cpu_ale_i = 1'b1;
    logic        cpu_fetch_strobe_i = 1'b1;
    logic [31:0] cpu_port_i = 32'hffffffff;
    logic        cpu_port0_oe_i = 1'b0;
    logic        ale_o, program_fetch_strobe_o, port0_oe_o, oscillator_run_o;
    logic        machine_phase_o, cpu_reset_o, cpu_halt_o, periph_halt_o, ext_program_o;
    logic [31:0] port_o;
    rpm_mode_t   mode_o;
    int          n_errors = 0;
    int          tests_run = 0;

    // ----------------------------------------------------------------
    // Clock, board and device
    // ----------------------------------------------------------------
    always #5 clk_i = ~clk_i;

    rpm_board board (.clk_i(clk_i), .oscillator_run_i(oscillator_run_o),
                     .oscillator_o(osc), .reset_pin_o(pin), .select_o(sel));

    rpm_ctrl uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .oscillator_input_i(osc), .reset_pin_i(pin),
        .external_program_select_i(sel), .power_write_i(power_write_i),
        .power_data_i(power_data_i), .irq_pending_i(irq_pending_i), .cpu_ale_i(cpu_ale_i),
        .cpu_fetch_strobe_i(cpu_fetch_strobe_i), .cpu_port_i(cpu_port_i),
        .cpu_port0_oe_i(cpu_port0_oe_i), .ale_o(ale_o),
        .program_fetch_strobe_o(program_fetch_strobe_o), .port_o(port_o),
        .port0_oe_o(port0_oe_o), .oscillator_run_o(oscillator_run_o),
        .machine_phase_o(machine_phase_o), .cpu_reset_o(cpu_reset_o),
        .cpu_halt_o(cpu_halt_o), .periph_halt_o(periph_halt_o),
        .ext_program_o(ext_program_o), .mode_o(mode_o));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic results();
        $display("errors %0d in %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s is %b", $time, what, got);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s is %h", $time, what, got);
        end
    endtask

    task automatic chk_mode(input rpm_mode_t got, input rpm_mode_t exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s is %b", $time, what, got);
        end
    endtask

    // Steps to just after a rising edge
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Bounded wait for a mode; a miss ends the run
    task automatic wait_mode(input rpm_mode_t exp, input int limit);
        int i;
        for (i = 0; i < limit && mode_o !== exp; i++) begin
            cycles(1);
        end
        chk_mode(mode_o, exp, "mode wait");
        if (mode_o !== exp) begin
            results();
        end
    endtask

    task automatic power_write(input logic [1:0] data);
        power_write_i = 1'b1;
        power_data_i  = data;
        cycles(1);
        power_write_i = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        board.set_select(1'b0);
        fork
            board.press_reset(40);
            begin
                cycles(16);
                rst_n_i = 1'b1;
                cycles(40);
                chk_mode(mode_o, MODE_RESET, "power-on hold");
                chk_bit(cpu_reset_o, 1'b1, "power-on core reset");
            end
        join
        wait_mode(MODE_RUN, 20);
        chk_bit(cpu_reset_o, 1'b0, "core reset");
        chk_bit(ext_program_o, 1'b0, "select capture");
        board.set_select(1'b1);
        cycles(10);
        chk_bit(ext_program_o, 1'b0, "select after reset");
    endtask

    task automatic test_divider();
        int   rises = 0;
        int   flips = 0;
        logic os;
        logic ph;
        os = osc;
        ph = machine_phase_o;
        repeat (400) begin
            cycles(1);
            if (osc && !os) rises++;
            if (machine_phase_o !== ph) flips++;
            os = osc;
            ph = machine_phase_o;
        end
        chk_bit(rises > 40 && flips >= rises - 1 && flips <= rises + 1, 1'b1, "divider");
    endtask

    task automatic test_idle();
        cpu_ale_i          = 1'b0;
        cpu_fetch_strobe_i = 1'b0;
        cpu_port0_oe_i     = 1'b1;
        cpu_port_i         = 32'h12345678;
        cycles(2);
        power_write(2'h1);
        wait_mode(MODE_IDLE, 3);
        chk_bit(cpu_halt_o, 1'b1, "idle halt");
        chk_bit(periph_halt_o, 1'b0, "idle peripherals");
        chk_bit(ale_o, 1'b1, "idle ale");
        chk_bit(program_fetch_strobe_o, 1'b1, "idle fetch");
        chk_bit(port0_oe_o, 1'b0, "idle port0 float");
        cycles(1);
        cpu_port_i = 32'hdeadbeef;
        power_write(2'h2);
        cycles(4);
        chk_mode(mode_o, MODE_IDLE, "write in idle");
        chk_word(port_o, 32'h12345678, "idle port hold");
        irq_pending_i = 1'b1;
        wait_mode(MODE_RUN, 3);
        irq_pending_i = 1'b0;
        chk_bit(cpu_halt_o, 1'b0, "idle exit");
        cycles(2);
        chk_word(port_o, 32'hdeadbeef, "run port");
    endtask

    task automatic test_pdown();
        cpu_port_i = 32'h0f0f0f0f;
        cycles(2);
        power_write(2'h3);
        wait_mode(MODE_PDOWN, 3);
        cpu_port_i = 32'h00000000;
        cycles(2);
        chk_bit(oscillator_run_o, 1'b0, "osc stop");
        chk_bit(ale_o, 1'b0, "pdown ale");
        chk_bit(program_fetch_strobe_o, 1'b0, "pdown fetch");
        chk_bit(port0_oe_o, 1'b0, "pdown port0 float");
        chk_word(port_o, 32'h0f0f0f0f, "pdown port hold");
        irq_pending_i = 1'b1;
        cycles(20);
        irq_pending_i = 1'b0;
        chk_mode(mode_o, MODE_PDOWN, "irq in pdown");
        fork
            board.press_reset(26);
            begin
                wait_mode(MODE_RESET, 300);
                chk_bit(cpu_reset_o, 1'b1, "pdown reset");
            end
        join
        wait_mode(MODE_RUN, 10);
        chk_bit(oscillator_run_o, 1'b1, "osc restart");
        chk_bit(periph_halt_o, 1'b0, "pdown exit");
        chk_bit(ext_program_o, 1'b1, "select pdown capture");
    endtask

    task automatic test_short_pulse();
        int bad = 0;
        fork
            board.press_reset(20);
            repeat (250) begin
                cycles(1);
                if (cpu_reset_o !== 1'b0) bad++;
            end
        join
        chk_bit(bad == 0, 1'b1, "short pulse");
        power_write(2'h1);
        wait_mode(MODE_IDLE, 3);
        chk_bit(port0_oe_o, 1'b1, "idle port0 drive");
        board.set_select(1'b0);
        fork
            board.press_reset(26);
            wait_mode(MODE_RESET, 300);
        join
        wait_mode(MODE_RUN, 10);
        chk_bit(cpu_halt_o, 1'b0, "idle reset exit");
        chk_bit(ext_program_o, 1'b0, "select recapture");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        test_reset();
        test_divider();
        test_idle();
        test_pdown();
        test_short_pulse();
        results();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        $display("unexpected at %0t: run hung", $time);
        results();
    end
endmodule // tb_top
